// File: ciee_core_entry.sv
// core end: interrupt recognition, pending, mask compare and exception entry
module ciee_core_entry (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   ciee_link_if.core              link,
   input  wire logic              dedicated_mode,
   input  wire logic              onchip_req,
   input  wire logic              insn_boundary,
   input  wire logic              psw_load,
   input  wire logic [15:0]       psw_load_value,
   output logic                   entry_busy,
   output logic                   entry_done,
   output logic [7:0]             entry_vector,
   output logic                   entry_spurious,
   output logic [15:0]            saved_psw,
   output logic [15:0]            psw,
   output logic [2:0]             pending_level
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, change taken when stages two and three agree
   logic [5:0] s1_r, s2_r, s3_r;          // stages for level, lines
   logic [5:0] pin_r, pin_nxt;            // filtered pin value
   logic [2:0] s1b_r, s2b_r, s3b_r;       // stages for dtack, autovector, bus error
   logic [2:0] ack_r, ack_nxt;            // filtered acknowledge answers

   // filter next value
   always_comb begin
      pin_nxt = pin_r;
      ack_nxt = ack_r;
      if (s2_r == s3_r) begin
         pin_nxt = s3_r;
      end
      if (s2b_r == s3b_r) begin
         ack_nxt = s3b_r;
      end
   end

   // synchroniser flops
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s1_r  <= 6'h38;
         s2_r  <= 6'h38;
         s3_r  <= 6'h38;
         pin_r <= 6'h38;
         s1b_r <= 3'h0;
         s2b_r <= 3'h0;
         s3b_r <= 3'h0;
         ack_r <= 3'h0;
      end else begin
         s1_r  <= {link.irq_line_n, link.irq_level};
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         pin_r <= pin_nxt;
         s1b_r <= {link.bus_error, link.autovector_request, link.dtack};
         s2b_r <= s1b_r;
         s3b_r <= s2b_r;
         ack_r <= ack_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request decode
   logic [2:0] user_level;                // level from the pins
   logic [2:0] req_level;                 // highest level including on-chip

   // decode by mode
   always_comb begin
      user_level = ciee_pkg::LEVEL_NONE;
      if (dedicated_mode == ciee_pkg::CIEE_MODE_DEDICATED) begin
         if (!pin_r[5]) begin
            user_level = 3'h7;
         end else if (!pin_r[4]) begin
            user_level = 3'h6;
         end else if (!pin_r[3]) begin
            user_level = 3'h1;
         end
      end else begin
         user_level = pin_r[2:0];
      end
      // level four held back for on-chip
      if (user_level == ciee_pkg::LEVEL_ONCHIP) begin
         user_level = ciee_pkg::LEVEL_NONE;
      end
      req_level = user_level;
      if (onchip_req && user_level < ciee_pkg::LEVEL_ONCHIP) begin
         req_level = ciee_pkg::LEVEL_ONCHIP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // entry state machine
   typedef enum logic [2:0] {
      CIEE_ST_RUN  = 3'b000,             // executing instructions
      CIEE_ST_SAVE = 3'b001,             // status word saved, mask raised
      CIEE_ST_IACK = 3'b011,             // acknowledge read
      CIEE_ST_DONE = 3'b010              // vector ready
   } ciee_state_type;

   ciee_state_type state_r, state_nxt;    // state
   logic [2:0]  pend_r, pend_nxt;         // pending level
   logic [2:0]  ack_lvl_r, ack_lvl_nxt;   // level being acknowledged
   logic [15:0] psw_r, psw_nxt;           // status word
   logic [15:0] save_r, save_nxt;         // saved copy
   logic [7:0]  vec_r, vec_nxt;           // vector number
   logic        spur_r, spur_nxt;         // spurious flag
   logic [2:0]  mask;                     // current mask

   assign mask = psw_r[ciee_pkg::PSW_MASK_LO +: ciee_pkg::LEVEL_W];

   // next state
   always_comb begin
      state_nxt   = state_r;
      pend_nxt    = pend_r;
      ack_lvl_nxt = ack_lvl_r;
      psw_nxt     = psw_r;
      save_nxt    = save_r;
      vec_nxt     = vec_r;
      spur_nxt    = spur_r;
      pend_nxt = req_level;
      if (psw_load && state_r == CIEE_ST_RUN) begin
         psw_nxt = psw_load_value;
      end
      unique case (state_r)
         CIEE_ST_RUN: begin
            // inhibit at or below mask, level seven included
            if (insn_boundary && pend_r != ciee_pkg::LEVEL_NONE && pend_r > mask) begin
               save_nxt    = psw_r;
               ack_lvl_nxt = pend_r;
               psw_nxt[ciee_pkg::PSW_SUPER] = 1'b1;
               psw_nxt[ciee_pkg::PSW_TRACE] = 1'b0;
               psw_nxt[ciee_pkg::PSW_MASK_LO +: ciee_pkg::LEVEL_W] = pend_r;
               state_nxt = CIEE_ST_SAVE;
            end
         end
         CIEE_ST_SAVE: begin
            state_nxt = CIEE_ST_IACK;
         end
         CIEE_ST_IACK: begin
            if (ack_r[2]) begin
               vec_nxt   = ciee_pkg::SPURIOUS_VEC;
               spur_nxt  = 1'b1;
               state_nxt = CIEE_ST_DONE;
            end else if (ack_r[1]) begin
               vec_nxt   = ciee_pkg::AUTOVEC_BASE + {5'h00, ack_lvl_r};
               spur_nxt  = 1'b0;
               state_nxt = CIEE_ST_DONE;
            end else if (ack_r[0]) begin
               vec_nxt   = link.vector_data;
               spur_nxt  = 1'b0;
               state_nxt = CIEE_ST_DONE;
            end
         end
         CIEE_ST_DONE: begin
            state_nxt = CIEE_ST_RUN;
         end
         default: begin
            state_nxt = CIEE_ST_RUN;
         end
      endcase
   end

   // state registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r   <= CIEE_ST_RUN;
         pend_r    <= ciee_pkg::LEVEL_NONE;
         ack_lvl_r <= ciee_pkg::LEVEL_NONE;
         psw_r     <= ciee_pkg::PSW_RESET;
         save_r    <= 16'h0000;
         vec_r     <= 8'h00;
         spur_r    <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         pend_r    <= pend_nxt;
         ack_lvl_r <= ack_lvl_nxt;
         psw_r     <= psw_nxt;
         save_r    <= save_nxt;
         vec_r     <= vec_nxt;
         spur_r    <= spur_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign link.iack_strobe = (state_r == CIEE_ST_IACK);
   assign link.iack_fc_cpu = (state_r == CIEE_ST_IACK);
   // level on address lines three to one
   assign link.iack_addr   = ciee_pkg::IACK_ADDR_BASE
                             | {20'h00000, ack_lvl_r, 1'b0};
   assign entry_busy       = (state_r != CIEE_ST_RUN);
   assign entry_done       = (state_r == CIEE_ST_DONE);
   assign entry_vector     = vec_r;
   assign entry_spurious   = spur_r;
   assign saved_psw        = save_r;
   assign psw              = psw_r;
   assign pending_level    = pend_r;
endmodule : ciee_core_entry

// File: ciee_pkg.sv
// package: shared constants for the interrupt recognition and exception entry block
package ciee_pkg;
   // field widths
   localparam int LEVEL_W = 3;                           // priority level / mask width
   localparam int PSW_W   = 16;                          // status word width
   localparam int VEC_W   = 8;                           // vector number width
   localparam int ADDR_W  = 24;                          // address bus width
   // status word field positions
   localparam int PSW_MASK_LO = 8;                       // mask field low bit
   localparam int PSW_TRACE   = 15;                      // trace enable bit
   localparam int PSW_SUPER   = 13;                      // supervisor state bit
   // reset value of the status word: supervisor, mask 7
   localparam logic [15:0] PSW_RESET = 16'h2700;
   // vectors
   localparam logic [7:0] AUTOVEC_BASE = 8'h18;          // autovector for level 0 base
   localparam logic [7:0] SPURIOUS_VEC = 8'h18;          // spurious interrupt vector
   // levels
   localparam logic [2:0] LEVEL_ONCHIP = 3'h4;           // reserved for on-chip peripherals
   localparam logic [2:0] LEVEL_NONE   = 3'h0;           // no request
   // acknowledge address: all high lines ones, level in bits 3..1
   localparam logic [23:0] IACK_ADDR_BASE = 24'hfffff0;
   localparam int IACK_LEVEL_LO = 1;                     // level field low bit in address
   // controller modes
   typedef enum logic {
      CIEE_MODE_NORMAL    = 1'b0,                        // encoded request lines
      CIEE_MODE_DEDICATED = 1'b1                         // one line each for levels 1, 6, 7
   } ciee_mode_type;
endpackage : ciee_pkg

// File: ciee_link_if.sv
// interface: request lines and acknowledge bus between core and requesters
interface ciee_link_if;
   logic [2:0]  irq_level;       // encoded request level (normal mode)
   logic [2:0]  irq_line_n;      // dedicated lines for levels 1, 6, 7, active low
   logic        iack_strobe;     // acknowledge read in progress
   logic [23:0] iack_addr;       // acknowledge address, level in low bits
   logic        iack_fc_cpu;     // function code marks cpu space cycle
   logic        dtack;           // device answers with vector
   logic [7:0]  vector_data;     // vector number from device
   logic        autovector_request; // autovector requested
   logic        bus_error;       // bus error during acknowledge
   // core end
   modport core (
      input  irq_level,
      input  irq_line_n,
      output iack_strobe,
      output iack_addr,
      output iack_fc_cpu,
      input  dtack,
      input  vector_data,
      input  autovector_request,
      input  bus_error
   );
   // requesting logic end
   modport requester (
      output irq_level,
      output irq_line_n,
      input  iack_strobe,
      input  iack_addr,
      input  iack_fc_cpu,
      output dtack,
      output vector_data,
      output autovector_request,
      output bus_error
   );
endinterface : ciee_link_if

// File: ciee_requester.sv
// requester end: drives request lines and answers acknowledge cycles
module ciee_requester (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   ciee_link_if.requester   link,
   input  wire logic        dedicated_mode,
   input  wire logic [2:0]  req_level,
   input  wire logic [7:0]  req_vector,
   input  wire logic        req_autovector,
   input  wire logic        req_fail,
   output logic             ack_seen
);
   ////////////////////////////////////////////////////////////////////////////
   // request lines, registered
   logic [2:0] lvl_r, lvl_nxt;            // encoded level
   logic [2:0] line_n_r, line_n_nxt;      // dedicated lines
   logic [2:0] ans_r, ans_nxt;            // dtack, autovector, bus error
   logic [7:0] vec_r, vec_nxt;            // vector on data lines
   logic       hit;                       // acknowledge addresses our level

   // answers only when the acknowledge cycle addresses our level
   assign hit = link.iack_strobe && link.iack_fc_cpu
                && link.iack_addr[ciee_pkg::IACK_LEVEL_LO +: 3] == req_level;

   // next values
   always_comb begin
      lvl_nxt    = 3'h0;
      line_n_nxt = 3'h7;
      // encoded, or one line each for levels 1, 6 and 7
      if (dedicated_mode == ciee_pkg::CIEE_MODE_DEDICATED) begin
         line_n_nxt[0] = !(req_level == 3'h1);
         line_n_nxt[1] = !(req_level == 3'h6);
         line_n_nxt[2] = !(req_level == 3'h7);
      end else begin
         lvl_nxt = req_level;
      end
      ans_nxt = 3'h0;
      vec_nxt = vec_r;
      if (hit) begin
         ans_nxt = {req_fail, req_autovector && !req_fail,
                    !req_autovector && !req_fail};
         vec_nxt = req_vector;
      end
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lvl_r    <= 3'h0;
         line_n_r <= 3'h7;
         ans_r    <= 3'h0;
         vec_r    <= 8'h00;
      end else begin
         lvl_r    <= lvl_nxt;
         line_n_r <= line_n_nxt;
         ans_r    <= ans_nxt;
         vec_r    <= vec_nxt;
      end
   end

   assign link.irq_level          = lvl_r;
   assign link.irq_line_n         = line_n_r;
   assign link.dtack              = ans_r[0];
   assign link.autovector_request = ans_r[1];
   assign link.bus_error          = ans_r[2];
   assign link.vector_data        = vec_r;
   assign ack_seen                = hit;
endmodule : ciee_requester

// File: ciee_link_checker.sv
// checker: wire-level assertions on the link between core and requester
module ciee_link_checker (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [2:0]  irq_level,
   input wire logic [2:0]  irq_line_n,
   input wire logic        iack_strobe,
   input wire logic [23:0] iack_addr,
   input wire logic        iack_fc_cpu,
   input wire logic        dtack,
   input wire logic        autovector_request,
   input wire logic        bus_error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   wire logic answer;                                    // any reply from the requester
   assign answer = dtack | autovector_request | bus_error;
   ////////////////////////////////////////////////////////////////////////////////
   // acknowledge cycle shape
   fc_marks_iack_a: assert property (iack_fc_cpu == iack_strobe)
      else $error("function code does not follow acknowledge strobe");
   addr_high_ones_a: assert property (iack_strobe |-> iack_addr[23:4] == 20'hfffff
      && !iack_addr[0]) else $error("acknowledge address high lines wrong");
   addr_level_a: assert property (iack_strobe |-> iack_addr[3:1] != 3'h0)
      else $error("acknowledge address carries level zero");
   addr_hold_a: assert property (iack_strobe && $past(iack_strobe) |-> $stable(iack_addr))
      else $error("acknowledge address moved during cycle");
   strobe_bound_a: assert property ($rose(iack_strobe) |-> ##[1:12] !iack_strobe)
      else $error("acknowledge strobe never ends");
   ////////////////////////////////////////////////////////////////////////////////
   // requester replies
   answer_cause_a: assert property ($rose(answer) |-> $past(iack_strobe))
      else $error("reply without acknowledge cycle");
   answer_bound_a: assert property ($rose(iack_strobe) |-> ##[1:2] answer)
      else $error("requester did not reply in time");
   reset_idle_a: assert property ($fell(sys_rst) |-> irq_level == 3'h0
      && irq_line_n == 3'h7 && !iack_strobe) else $error("link not idle after reset");
   // main scenarios reached
   cover property ($rose(iack_strobe) ##[1:2] dtack);
   cover property ($rose(iack_strobe) ##[1:2] autovector_request);
   cover property ($rose(iack_strobe) ##[1:2] bus_error);
endmodule : ciee_link_checker

// File: core_interrupt_exception_entry_tb_top.sv
// testbench: both link ends joined, requests driven through the requester end
module core_interrupt_exception_entry_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, sys_rst;              // 250 MHz clock, sync reset
   logic        dedicated_mode, onchip_req;    // mode and on-chip request
   logic        insn_boundary, psw_load;       // boundary strobe, status write
   logic [15:0] psw_load_value, saved_psw, psw; // status words
   logic [2:0]  req_level, pending_level;      // asked and pending levels
   logic [7:0]  req_vector, entry_vector;      // vectors
   logic        req_autovector, req_fail;      // reply kind
   logic        entry_busy, entry_done, entry_spurious;
   int          failures, n_checks;            // counters
   ciee_link_if ciee_link_if_inst ();
   ciee_core_entry ciee_core_entry_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(ciee_link_if_inst), .dedicated_mode(dedicated_mode), .onchip_req(onchip_req),
      .insn_boundary(insn_boundary), .psw_load(psw_load), .psw_load_value(psw_load_value),
      .entry_busy(entry_busy), .entry_done(entry_done), .entry_vector(entry_vector),
      .entry_spurious(entry_spurious), .saved_psw(saved_psw), .psw(psw),
      .pending_level(pending_level));
   ciee_requester ciee_requester_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(ciee_link_if_inst), .dedicated_mode(dedicated_mode), .req_level(req_level),
      .req_vector(req_vector), .req_autovector(req_autovector), .req_fail(req_fail),
      .ack_seen());
   ciee_link_checker ciee_link_checker_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .irq_level(ciee_link_if_inst.irq_level), .irq_line_n(ciee_link_if_inst.irq_line_n),
      .iack_strobe(ciee_link_if_inst.iack_strobe), .iack_addr(ciee_link_if_inst.iack_addr),
      .iack_fc_cpu(ciee_link_if_inst.iack_fc_cpu), .dtack(ciee_link_if_inst.dtack),
      .autovector_request(ciee_link_if_inst.autovector_request),
      .bus_error(ciee_link_if_inst.bus_error));
   ////////////////////////////////////////////////////////////////////////////////
   // clock generator
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // compare seen against expected, count both outcomes
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // print counts and verdict, then stop
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   // software write of the status word
   task automatic load_psw(logic [15:0] v);
      @(posedge sys_clk);
      psw_load       <= 1'b1;
      psw_load_value <= v;
      @(posedge sys_clk);
      psw_load       <= 1'b0;
      @(negedge sys_clk);
      check("loaded psw", psw, v);
   endtask : load_psw
   // raise a request, offer a boundary, wait for the entry and check it
   task automatic entry(logic [2:0] lvl, logic [7:0] vec, logic av, logic fl,
                        logic [7:0] exp_vec);
      logic [15:0] old;
      logic        seen;
      seen = 1'b0;
      @(posedge sys_clk);
      req_level      <= lvl;
      req_vector     <= vec;
      req_autovector <= av;
      req_fail       <= fl;
      repeat (8) @(posedge sys_clk);
      old = psw;
      insn_boundary <= 1'b1;
      @(posedge sys_clk);
      insn_boundary <= 1'b0;
      for (int k = 0; k < 40 && !seen; k++) begin
         @(negedge sys_clk);
         seen = (entry_done === 1'b1);
      end
      check("entry done", {15'h0, seen}, 16'h1);
      check("vector", entry_vector, exp_vec);
      check("spurious", entry_spurious, fl);
      check("saved psw", saved_psw, old);
      check("new psw", psw, (old & 16'h78ff) | 16'h2000 | {5'h0, lvl, 8'h0});
      check("entry busy", {15'h0, entry_busy}, 16'h1);
      @(posedge sys_clk);
      req_level      <= 3'h0;
      req_autovector <= 1'b0;
      req_fail       <= 1'b0;
      repeat (10) @(posedge sys_clk);
      $display("test entry level %0d done", lvl);
   endtask : entry
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      failures = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      {dedicated_mode, onchip_req, insn_boundary, psw_load} = 4'h0;
      psw_load_value = 16'h0;
      {req_level, req_vector, req_autovector, req_fail} = 13'h0;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
      check("reset psw", psw, 16'h2700);
      load_psw(16'h8300);
      // level four on the pins is never taken as pending
      @(posedge sys_clk);
      req_level <= 3'h4;
      repeat (10) @(negedge sys_clk);
      check("pin level four", pending_level, 3'h0);
      $display("test pin level four done");
      // level two at or below mask three waits and is not taken
      @(posedge sys_clk);
      req_level <= 3'h2;
      repeat (8) @(posedge sys_clk);
      insn_boundary <= 1'b1;
      @(posedge sys_clk);
      insn_boundary <= 1'b0;
      repeat (20) @(negedge sys_clk);
      check("masked psw", psw, 16'h8300);
      check("masked pending", pending_level, 3'h2);
      check("masked busy", {15'h0, entry_busy}, 16'h0);
      $display("test masked request done");
      entry(3'h5, 8'h40, 1'b0, 1'b0, 8'h40);
      load_psw(16'h0000);
      entry(3'h6, 8'h00, 1'b1, 1'b0, 8'h1e);
      load_psw(16'h0000);
      entry(3'h3, 8'h33, 1'b0, 1'b1, 8'h18);
      dedicated_mode <= 1'b1;
      // mask six: level seven is above it and is taken
      load_psw(16'h2600);
      entry(3'h7, 8'h55, 1'b0, 1'b0, 8'h55);
      load_psw(16'h0000);
      entry(3'h1, 8'h21, 1'b0, 1'b0, 8'h21);
      // on-chip request holds the reserved level
      onchip_req <= 1'b1;
      repeat (10) @(negedge sys_clk);
      check("on-chip level", pending_level, 3'h4);
      $display("test on-chip request done");
      end_of_test();
   end
   // watchdog against a hang
   initial begin
      repeat (3000) @(posedge sys_clk);
      failures++;
      end_of_test();
   end
endmodule : core_interrupt_exception_entry_tb_top
